// [core/vcmp_pkg.sv]
// Shared constants and carrier types for the vector compare / convert unit.
// Assumes a single core clock; issue logic and bus master share that clock.
package vcmp_pkg;

	// ----------------------------------------
	// Instruction fields (bit 0 = LSB)
	// ----------------------------------------
	localparam logic [5:0]  PRIMARY_VEC  = 6'h04;
	localparam int          PRIMARY_LSB  = 26;
	localparam int          SCALE_LSB    = 16;
	localparam int          RECORD_POS   = 10;
	localparam logic [9:0]  XO_GT_FP     = 10'h2C6;
	localparam logic [9:0]  XO_GT_SB     = 10'h306;
	localparam logic [9:0]  XO_GT_SH     = 10'h346;
	localparam logic [9:0]  XO_GT_SW     = 10'h386;
	localparam logic [9:0]  XO_GT_UB     = 10'h206;
	localparam logic [9:0]  XO_GT_UH     = 10'h246;
	localparam logic [9:0]  XO_GT_UW     = 10'h286;
	localparam logic [10:0] XO_CVT_SX    = 11'h3CA;

	// ----------------------------------------
	// Lane sizes
	// ----------------------------------------
	localparam logic [1:0]  SZ_BYTE      = 2'h0;
	localparam logic [1:0]  SZ_HALF      = 2'h1;
	localparam logic [1:0]  SZ_WORD      = 2'h2;

	// ----------------------------------------
	// Conversion limits
	// ----------------------------------------
	localparam logic [31:0] SINT_MAX     = 32'h7FFFFFFF;
	localparam logic [31:0] SINT_MIN     = 32'h80000000;
	localparam logic [9:0]  SHIFT_BIAS   = 10'h096;
	localparam logic [9:0]  SHIFT_SAT    = 10'h008;
	localparam logic [9:0]  SHIFT_ZERO   = 10'h3E8;
	localparam logic [23:0] MANT_MIN_NEG = 24'h800000;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [31:0] VSC_OFFSET   = 32'h00000000;
	localparam logic [31:0] CRF_OFFSET   = 32'h00000004;
	localparam int          CLAMP_BIT    = 0;
	localparam int          FLUSH_BIT    = 16;
	localparam logic        CLAMP_RESET  = 1'b0;
	localparam logic        FLUSH_RESET  = 1'b0;
	localparam logic [3:0]  CRF_RESET    = 4'h0;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic         valid;
		logic [31:0]  instr;
		logic [127:0] source_a_operand;
		logic [127:0] source_b_operand;
	} issue_type;

	typedef struct packed {
		logic         valid;
		logic [127:0] destination_operand;
		logic         cr_we;
		logic [3:0]   compare_result_field;
	} result_type;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axi_m2s_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_s2m_type;

endpackage

// [core/fp_to_sfix.sv]
// One single-precision word to saturated signed fixed point.
// Assumes scale_exponent is the 5-bit unsigned immediate.
`timescale 1ns/1ns
module fp_to_sfix (
	input  wire logic [31:0] i_word,
	input  wire logic [4:0]  i_scale,
	output logic      [31:0] o_fixed,
	output logic             o_clamp
);
	import vcmp_pkg::*;

	logic [7:0]  exp_f;
	logic [23:0] mant;
	logic [9:0]  shift;
	logic [9:0]  rshift;
	logic [31:0] mag;
	logic        is_nan;
	logic        is_inf;
	logic        over;

	// ----------------------------------------
	// Scaled truncating convert
	// ----------------------------------------
	always_comb begin
		exp_f  = i_word[30:23];
		mant   = {|exp_f, i_word[22:0]};
		is_nan = (&exp_f) & (|i_word[22:0]);
		is_inf = (&exp_f) & ~(|i_word[22:0]);
		shift  = {2'h0, exp_f} + {5'h00, i_scale} - SHIFT_BIAS;
		rshift = 10'h000 - shift;
		mag    = 32'h00000000;
		if (!shift[9]) begin
			mag = {8'h00, mant} << shift[3:0];
		end else if (shift > SHIFT_ZERO) begin
			mag = {8'h00, mant} >> rshift[4:0];
		end
		over = is_inf
			| (!shift[9] && shift > SHIFT_SAT)
			| (shift == SHIFT_SAT && !(i_word[31] && mant == MANT_MIN_NEG));
		o_clamp = 1'b0;
		if (is_nan) begin
			o_fixed = 32'h00000000;
		end else if (over) begin
			o_fixed = i_word[31] ? SINT_MIN : SINT_MAX;
			o_clamp = 1'b1;
		end else begin
			o_fixed = i_word[31] ? 32'h00000000 - mag : mag;
		end
	end

endmodule

// [core/vcmp_gt_cvt.sv]
// Vector greater-than compares and signed fixed-point convert, with an
// AXI4-Lite window on the vector status/control bits.
// Assumes issue logic and the bus master run on I_CLOCK.
//
// Operation
// - Float compare: word lane all ones when A exceeds B, else zeros.
// - Float compare: a NaN in either lane gives a zero word.
// - Signed byte compare over sixteen lanes, mask ones when A greater.
// - Signed halfword compare over eight lanes, mask ones when A greater.
// - Signed word compare over four lanes, mask ones when A greater.
// - Unsigned byte compare over sixteen lanes, mask ones when A greater.
// - Unsigned halfword compare over eight lanes, mask ones when A greater.
// - Unsigned word compare over four lanes, mask ones when A greater.
// - Recorded field is all-true, zero, none-true, zero from the top.
// - Result field changes only when the record bit is set.
// - Convert scales B words by two to the scale, truncates to integer.
// - Convert clamps to the signed 32-bit maximum and minimum.
// - Converted word holds 32 minus scale integer bits, then fraction bits.
// - Convert truncates toward zero only; other rounding is software's job.
// - Saturation sets the clamp flag and touches nothing else.
// - With denormal flush on, denormal compare inputs count as zero.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module vcmp_gt_cvt (
	input  wire logic                  I_CLOCK,
	input  wire logic                  I_SRST,
	input  wire vcmp_pkg::issue_type   I_ISSUE,
	input  wire vcmp_pkg::axi_m2s_type I_AXI,
	output vcmp_pkg::result_type       O_RESULT,
	output vcmp_pkg::axi_s2m_type      O_AXI
);
	import vcmp_pkg::*;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [8:0] {
		OP_NONE = 9'b000000001,
		OP_GTFP = 9'b000000010,
		OP_GTSB = 9'b000000100,
		OP_GTSH = 9'b000001000,
		OP_GTSW = 9'b000010000,
		OP_GTUB = 9'b000100000,
		OP_GTUH = 9'b001000000,
		OP_GTUW = 9'b010000000,
		OP_CVSX = 9'b100000000
	} op_type;

	typedef struct packed {
		result_type  res;
		logic        clamp_flag;
		logic        denormal_flush;
		axi_s2m_type bus;
		logic        have_aw;
		logic [31:0] aw_addr;
		logic        have_w;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
	} state_type;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	state_type    s_r;
	state_type    s_nxt;
	op_type       op;
	logic [127:0] mask;
	logic [127:0] cvt_data;
	logic [3:0]   cvt_clamp;
	logic         do_write;
	logic         aw_take;
	logic         w_take;
	logic         ar_take;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic op_type decode(input logic [31:0] instr);
		op_type o;
		o = OP_NONE;
		if (instr[31:PRIMARY_LSB] == PRIMARY_VEC) begin
			if (instr[10:0] == XO_CVT_SX) begin
				o = OP_CVSX;
			end else begin
				case (instr[9:0])
					XO_GT_FP: o = OP_GTFP;
					XO_GT_SB: o = OP_GTSB;
					XO_GT_SH: o = OP_GTSH;
					XO_GT_SW: o = OP_GTSW;
					XO_GT_UB: o = OP_GTUB;
					XO_GT_UH: o = OP_GTUH;
					XO_GT_UW: o = OP_GTUW;
					default:  o = OP_NONE;
				endcase
			end
		end
		return o;
	endfunction

	// Sign bit flipped so one unsigned compare serves both kinds
	function automatic logic [127:0] int_gt(
		input logic [127:0] a,
		input logic [127:0] b,
		input logic [1:0]   sz,
		input logic         sgn
	);
		logic [127:0] m;
		m = '0;
		unique case (sz)
			SZ_BYTE: begin
				for (int i = 0; i < 16; i++) begin
					m[i*8 +: 8] = {8{(a[i*8 +: 8] ^ {sgn, 7'h00})
						> (b[i*8 +: 8] ^ {sgn, 7'h00})}};
				end
			end
			SZ_HALF: begin
				for (int i = 0; i < 8; i++) begin
					m[i*16 +: 16] = {16{(a[i*16 +: 16] ^ {sgn, 15'h0000})
						> (b[i*16 +: 16] ^ {sgn, 15'h0000})}};
				end
			end
			SZ_WORD: begin
				for (int i = 0; i < 4; i++) begin
					m[i*32 +: 32] = {32{(a[i*32 +: 32] ^ {sgn, 31'h00000000})
						> (b[i*32 +: 32] ^ {sgn, 31'h00000000})}};
				end
			end
			default: m = '0;
		endcase
		return m;
	endfunction

	function automatic logic fp_gt(
		input logic [31:0] a,
		input logic [31:0] b,
		input logic        flush
	);
		logic [30:0] ma;
		logic [30:0] mb;
		logic        sa;
		logic        sb;
		logic        gt;
		ma = a[30:0];
		mb = b[30:0];
		if (flush && a[30:23] == 8'h00) begin
			ma = 31'h00000000;
		end
		if (flush && b[30:23] == 8'h00) begin
			mb = 31'h00000000;
		end
		sa = a[31] & (|ma);
		sb = b[31] & (|mb);
		if (sa != sb) begin
			gt = sb;
		end else if (!sa) begin
			gt = ma > mb;
		end else begin
			gt = ma < mb;
		end
		if ((&a[30:23] && |a[22:0]) || (&b[30:23] && |b[22:0])) begin
			gt = 1'b0;
		end
		return gt;
	endfunction

	function automatic logic [127:0] fp_gt4(
		input logic [127:0] a,
		input logic [127:0] b,
		input logic         flush
	);
		logic [127:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*32 +: 32] = {32{fp_gt(a[i*32 +: 32], b[i*32 +: 32], flush)}};
		end
		return m;
	endfunction

	// ----------------------------------------
	// Bus helpers
	// ----------------------------------------
	function automatic logic is_map(input logic [31:0] addr, input logic [31:0] off);
		return {addr[31:2], 2'h0} == off;
	endfunction

	// Summary field of a whole mask
	function automatic logic [3:0] field_of(input logic [127:0] m);
		return {&m, 1'b0, ~|m, 1'b0};
	endfunction

	// Read response and data of one register word
	function automatic logic [33:0] read_word(
		input logic [31:0] addr,
		input state_type   s
	);
		logic [33:0] q;
		q = {RESP_OKAY, 32'h00000000};
		if (is_map(addr, VSC_OFFSET)) begin
			q[CLAMP_BIT] = s.clamp_flag;
			q[FLUSH_BIT] = s.denormal_flush;
		end else if (is_map(addr, CRF_OFFSET)) begin
			q[3:0] = s.res.compare_result_field;
		end else begin
			q[33:32] = RESP_SLVERR;
		end
		return q;
	endfunction

	// ----------------------------------------
	// Convert lanes
	// ----------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_cvt
		fp_to_sfix u_cvt (
			.i_word  (I_ISSUE.source_b_operand[g*32 +: 32]),
			.i_scale (I_ISSUE.instr[SCALE_LSB +: 5]),
			.o_fixed (cvt_data[g*32 +: 32]),
			.o_clamp (cvt_clamp[g])
		);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		op = decode(I_ISSUE.instr);
		mask = '0;
		s_nxt.res.valid = 1'b0;
		s_nxt.res.cr_we = 1'b0;

		// ----------------------------------------
		// Bus handshakes
		// ----------------------------------------
		aw_take = I_AXI.awvalid & s_r.bus.awready;
		w_take = I_AXI.wvalid & s_r.bus.wready;
		ar_take = I_AXI.arvalid & s_r.bus.arready;
		if (aw_take) begin
			s_nxt.have_aw = 1'b1;
			s_nxt.aw_addr = I_AXI.awaddr;
		end
		if (w_take) begin
			s_nxt.have_w = 1'b1;
			s_nxt.w_data = I_AXI.wdata;
			s_nxt.w_strb = I_AXI.wstrb;
		end
		if (s_r.bus.bvalid && I_AXI.bready) begin
			s_nxt.bus.bvalid = 1'b0;
		end

		// ----------------------------------------
		// Write channel
		// ----------------------------------------
		do_write = s_r.have_aw & s_r.have_w & ~s_r.bus.bvalid;
		if (do_write) begin
			s_nxt.have_aw = 1'b0;
			s_nxt.have_w = 1'b0;
			s_nxt.bus.bvalid = 1'b1;
			s_nxt.bus.bresp = RESP_OKAY;
			if (is_map(s_r.aw_addr, VSC_OFFSET)) begin
				if (s_r.w_strb[CLAMP_BIT/8]) begin
					s_nxt.clamp_flag = s_r.w_data[CLAMP_BIT];
				end
				if (s_r.w_strb[FLUSH_BIT/8]) begin
					s_nxt.denormal_flush = s_r.w_data[FLUSH_BIT];
				end
			end else if (!is_map(s_r.aw_addr, CRF_OFFSET)) begin
				s_nxt.bus.bresp = RESP_SLVERR;
			end
		end
		s_nxt.bus.awready = ~s_nxt.have_aw & ~s_nxt.bus.bvalid;
		s_nxt.bus.wready = ~s_nxt.have_w & ~s_nxt.bus.bvalid;

		// ----------------------------------------
		// Read channel
		// ----------------------------------------
		if (s_r.bus.rvalid && I_AXI.rready) begin
			s_nxt.bus.rvalid = 1'b0;
		end
		if (ar_take) begin
			s_nxt.bus.rvalid = 1'b1;
			{s_nxt.bus.rresp, s_nxt.bus.rdata} = read_word(I_AXI.araddr, s_r);
		end
		s_nxt.bus.arready = ~s_nxt.bus.rvalid;

		// ----------------------------------------
		// Execute
		// ----------------------------------------
		if (I_ISSUE.valid) begin
			unique case (op)
				OP_GTFP: mask = fp_gt4(I_ISSUE.source_a_operand,
					I_ISSUE.source_b_operand, s_r.denormal_flush);
				OP_GTSB: mask = int_gt(I_ISSUE.source_a_operand,
					I_ISSUE.source_b_operand, SZ_BYTE, 1'b1);
				OP_GTSH: mask = int_gt(I_ISSUE.source_a_operand,
					I_ISSUE.source_b_operand, SZ_HALF, 1'b1);
				OP_GTSW: mask = int_gt(I_ISSUE.source_a_operand,
					I_ISSUE.source_b_operand, SZ_WORD, 1'b1);
				OP_GTUB: mask = int_gt(I_ISSUE.source_a_operand,
					I_ISSUE.source_b_operand, SZ_BYTE, 1'b0);
				OP_GTUH: mask = int_gt(I_ISSUE.source_a_operand,
					I_ISSUE.source_b_operand, SZ_HALF, 1'b0);
				OP_GTUW: mask = int_gt(I_ISSUE.source_a_operand,
					I_ISSUE.source_b_operand, SZ_WORD, 1'b0);
				OP_CVSX: mask = cvt_data;
				OP_NONE: mask = '0;
			endcase
			if (op != OP_NONE) begin
				s_nxt.res.valid = 1'b1;
				s_nxt.res.destination_operand = mask;
			end
			if (op != OP_NONE && op != OP_CVSX && I_ISSUE.instr[RECORD_POS]) begin
				s_nxt.res.cr_we = 1'b1;
				s_nxt.res.compare_result_field = field_of(mask);
			end
			// Set wins over a same-cycle software clear
			if (op == OP_CVSX && |cvt_clamp) begin
				s_nxt.clamp_flag = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (I_SRST) begin
			s_r <= '0;
			s_r.clamp_flag <= CLAMP_RESET;
			s_r.denormal_flush <= FLUSH_RESET;
			s_r.res.compare_result_field <= CRF_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign O_RESULT = s_r.res;
	assign O_AXI = s_r.bus;

endmodule

// [test/vcmp_gt_cvt_chk.sv]
// Port checks for the compare/convert unit.
// Assumes binding into vcmp_gt_cvt; one clock.
`timescale 1ns/1ns
module vcmp_gt_cvt_chk (
	input wire logic                  I_CLOCK,
	input wire logic                  I_SRST,
	input wire vcmp_pkg::issue_type   I_ISSUE,
	input wire vcmp_pkg::axi_m2s_type I_AXI,
	input wire vcmp_pkg::result_type  O_RESULT,
	input wire vcmp_pkg::axi_s2m_type O_AXI
);
	import vcmp_pkg::*;
	wire logic [31:0]  ins = I_ISSUE.instr;
	wire logic [127:0] a   = I_ISSUE.source_a_operand;
	wire logic [127:0] b   = I_ISSUE.source_b_operand;
	wire logic [127:0] d   = O_RESULT.destination_operand;
	default clocking dc @(posedge I_CLOCK); endclocking
	default disable iff (I_SRST);
	// ----
	// Issue steps
	// ----
	sequence s_cmp(xo);
		I_ISSUE.valid && ins[31:26] == PRIMARY_VEC && ins[9:0] == xo;
	endsequence
	sequence s_cvt;
		I_ISSUE.valid && ins[31:26] == PRIMARY_VEC && ins[10:0] == XO_CVT_SX;
	endsequence
	AST_CVT_ANS: assert property (s_cvt |=> O_RESULT.valid && !O_RESULT.cr_we)
		else $error("convert answer wrong");
	AST_REC: assert property (
		s_cmp(XO_GT_SH) |=> O_RESULT.valid && O_RESULT.cr_we == $past(ins[RECORD_POS]))
		else $error("record pulse wrong");
	AST_HOLD: assert property (
		!O_RESULT.cr_we |-> $stable(O_RESULT.compare_result_field))
		else $error("field moved");
	AST_FIELD: assert property (
		O_RESULT.cr_we |-> O_RESULT.compare_result_field == {&d, 1'b0, ~|d, 1'b0})
		else $error("field format wrong");
	AST_UW: assert property (
		s_cmp(XO_GT_UW) |=> d[31:0] == {32{$past(a[31:0]) > $past(b[31:0])}})
		else $error("unsigned word lane wrong");
	AST_SW: assert property (
		s_cmp(XO_GT_SW) |=>
		d[127:96] == {32{$signed($past(a[127:96])) > $signed($past(b[127:96]))}})
		else $error("signed word lane wrong");
	AST_SB: assert property (
		s_cmp(XO_GT_SB) |=>
		d[127:120] == {8{$signed($past(a[127:120])) > $signed($past(b[127:120]))}})
		else $error("signed byte lane wrong");
	AST_NAN: assert property (
		s_cmp(XO_GT_FP) ##0 (&a[30:23] && |a[22:0]) |=> d[31:0] == 32'h0)
		else $error("nan lane not zero");
	AST_SAT: assert property (
		s_cvt ##0 b[31:0] == 32'h7F800000 |=> d[31:0] == SINT_MAX)
		else $error("no clamp to maximum");
endmodule
bind vcmp_gt_cvt vcmp_gt_cvt_chk i_chk (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_ISSUE(I_ISSUE),
	.I_AXI(I_AXI), .O_RESULT(O_RESULT), .O_AXI(O_AXI));

// [test/core_model.sv]
// Issue-side core model: drives issue, logs results.
// Assumes one-cycle result pulses on the shared clock.
`timescale 1ns/1ns
module core_model (
	input  wire logic                 i_clock,
	input  wire vcmp_pkg::result_type i_result,
	output vcmp_pkg::issue_type       o_issue
);
	import vcmp_pkg::*;
	result_type got[$];
	initial o_issue = '0;
	always @(negedge i_clock) if (i_result.valid) got.push_back(i_result);
	// ----
	// Issue tasks
	// ----
	task send(input logic [31:0] ins, input logic [127:0] a, b);
		@(posedge i_clock);
		o_issue <= '{1'b1, ins, a, b};
	endtask
	// Released lines show inverted values
	task idle();
		@(posedge i_clock);
		o_issue <= ~o_issue;
	endtask
endmodule

// [test/vcmp_gt_cvt_tb.sv]
// Self-checking bench for the compare/convert unit.
// Assumes core_model on issue side; bench is the AXI4-Lite master.
`timescale 1ns/1ns
module vcmp_gt_cvt_tb;
	import vcmp_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	axi_m2s_type  m = '0;
	axi_s2m_type  s;
	issue_type    iss;
	result_type   res, r;
	int           miscompares = 0;
	int           n_checks = 0;
	logic [3:0]   fld = CRF_RESET;
	logic [127:0] e;
	logic [127:0] pa[3] = '{128'h40000000_80000000_FFFF0001_7FC00000,
		128'h3F800000_00000000_00010001_3F800000, {16{8'h7F}}};
	logic [127:0] pb[3] = '{128'h3F800000_00000000_00010001_3F800000,
		128'h40000000_80000000_FFFF0001_7FC00000, 128'h0};
	logic [9:0]   ops[7] = '{XO_GT_FP, XO_GT_SB, XO_GT_SH, XO_GT_SW, XO_GT_UB, XO_GT_UH, XO_GT_UW};
	logic [127:0] cb[3] = '{128'hBF400000_3F800000_C0300000_3FC00000,
		128'hCF000000_4F000000_C0300000_7F800000, 128'hCF800000_00000000_BF000000_30000000};
	logic [127:0] ce[3] = '{128'hFFFFFFF4_00000010_FFFFFFD4_00000018,
		128'h80000000_7FFFFFFF_FFFFFFFE_7FFFFFFF, 128'h80000000_00000000_C0000000_00000001};
	logic [4:0]   sc[3] = '{5'h04, 5'h00, 5'h1F};
	logic [31:0]  vs[3] = '{32'h00010000, 32'h00010001, 32'h00010001};
	always #4 clk = ~clk;
	vcmp_gt_cvt i_dut (.I_CLOCK(clk), .I_SRST(rst), .I_ISSUE(iss), .I_AXI(m), .O_RESULT(res),
		.O_AXI(s));
	core_model i_core (.i_clock(clk), .i_result(res), .o_issue(iss));
	// ----
	// Helpers
	// ----
	function automatic logic [32:0] fk(input logic [32:0] v);
		if (v[30:0] == 31'h0) v = 33'h0;
		return v[31] ? {1'b0, ~v[31:0]} : {1'b0, v[31:0] | 32'h80000000};
	endfunction
	function automatic logic [127:0] gt(input logic [9:0] xo, input logic [127:0] a, b);
		logic [127:0] q;
		int w;
		logic [32:0] x, y;
		logic nan;
		q = '0;
		w = (xo == XO_GT_SB || xo == XO_GT_UB) ? 8 : (xo == XO_GT_SH || xo == XO_GT_UH) ? 16 : 32;
		for (int i = 0; i < 128; i += w) begin
			x = {1'b0, 32'(a >> i)} & ((33'h1 << w) - 1);
			y = {1'b0, 32'(b >> i)} & ((33'h1 << w) - 1);
			nan = 1'b0;
			if (xo == XO_GT_SB || xo == XO_GT_SH || xo == XO_GT_SW) begin
				x ^= 33'h1 << (w - 1);
				y ^= 33'h1 << (w - 1);
			end
			if (xo == XO_GT_FP) begin
				nan = (&x[30:23] && |x[22:0]) || (&y[30:23] && |y[22:0]);
				x = fk(x);
				y = fk(y);
			end
			if (x > y && !nan) q = q | 128'(((129'h1 << w) - 1) << i);
		end
		return q;
	endfunction
	task wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [127:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(inout int n);
		n++;
		if (n > 100) begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [31:0] ad, dt, input logic [1:0] er);
		int n = 0;
		logic aw, w, bv;
		logic [1:0] rs;
		@(posedge clk);
		m <= '{1'b1, ad, 1'b1, dt, 4'hF, 1'b1, 1'b0, m.araddr, 1'b0};
		do begin
			@(negedge clk);
			tick(n);
			aw = s.awready;
			w = s.wready;
			bv = s.bvalid;
			rs = s.bresp;
			@(posedge clk);
			if (aw) m.awvalid <= 1'b0;
			if (w) m.wvalid <= 1'b0;
		end while (!bv);
		m.bready <= 1'b0;
		chk(rs, er);
	endtask
	task automatic rd(input logic [31:0] ad, ex, input logic [1:0] er);
		int n = 0;
		logic ar, rv;
		logic [31:0] dt;
		logic [1:0] rs;
		@(posedge clk);
		m.arvalid <= 1'b1;
		m.araddr <= ad;
		m.rready <= 1'b1;
		do begin
			@(negedge clk);
			tick(n);
			ar = s.arready;
			rv = s.rvalid;
			dt = s.rdata;
			rs = s.rresp;
			@(posedge clk);
			if (ar) m.arvalid <= 1'b0;
		end while (!rv);
		m.rready <= 1'b0;
		chk(dt, ex);
		chk(rs, er);
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(VSC_OFFSET, 32'h0, RESP_OKAY);
		rd(CRF_OFFSET, 32'h0, RESP_OKAY);
		rd(32'h8, 32'h0, RESP_SLVERR);
		foreach (ops[k]) for (int j = 0; j < 3; j++)
			i_core.send({PRIMARY_VEC, 15'h0, ~j[0], ops[k]}, pa[j], pb[j]);
		i_core.send({6'h05, 26'h306}, pa[0], pb[0]);
		i_core.idle();
		repeat (2) @(posedge clk);
		chk(i_core.got.size(), 21);
		foreach (ops[k]) for (int j = 0; j < 3; j++) begin
			r = i_core.got.pop_front();
			e = gt(ops[k], pa[j], pb[j]);
			if (!j[0]) fld = {&e, 1'b0, ~|e, 1'b0};
			chk(r.destination_operand, e);
			chk(r.cr_we, !j[0]);
			chk(r.compare_result_field, fld);
		end
		wr(VSC_OFFSET, 32'h00010000, RESP_OKAY);
		i_core.send({PRIMARY_VEC, 16'h0, XO_GT_FP}, 128'h1, 128'h0);
		i_core.idle();
		repeat (2) @(posedge clk);
		r = i_core.got.pop_front();
		chk(r.destination_operand, 128'h0);
		for (int c = 0; c < 3; c++) begin
			i_core.send({PRIMARY_VEC, 5'h0, sc[c], 5'h0, XO_CVT_SX}, ~cb[c], cb[c]);
			i_core.idle();
			repeat (2) @(posedge clk);
			r = i_core.got.pop_front();
			chk(r.destination_operand, ce[c]);
			rd(VSC_OFFSET, vs[c], RESP_OKAY);
		end
		wr(VSC_OFFSET, 32'h0, RESP_OKAY);
		rd(VSC_OFFSET, 32'h0, RESP_OKAY);
		wr(CRF_OFFSET, 32'h0, RESP_OKAY);
		wr(32'hC, 32'h1, RESP_SLVERR);
		rd(CRF_OFFSET, {28'h0, fld}, RESP_OKAY);
		wrap_up();
	end
endmodule
